// >>> pct_map.vh
// register map, field positions and timing constants of the pwm capture timer pair
`ifndef PCT_MAP_VH
`define PCT_MAP_VH
// Summary of operation
// - counting clock is system clock divided by 1..128 from a 3-bit code
// - divide code takes effect at once; change it only while stopped
// - 16-bit up-counter advances on each prescaled tick while enabled
// - software write loads counter directly; stop timer first
// - high byte read first latches low byte for a coherent read
// - mode bit 0 selects input capture, 1 selects output compare
// - output low while count at or below duty, high above; polarity inverts
// - period register sets pwm period, duty register sets duty
// - duty equal to period gives constant level set by polarity
// - duty of zero gives a one-tick pulse each period
// - output mode: count equal to duty sets match flag, counting continues
// - output mode: count equal to period sets overflow flag, clears counter
// - single shot clears enable after overflow or period detection
// - filter code rejects pulses under 4, 8 or 16 clocks; 00 bypasses
// - filtered input lags raw input by 5-6, 9-10 or 17-18 clocks
// - capture polarity 0 measures rise-to-rise and high width; 1 the inverse
// - pulse-ending edge copies count to duty, sets width flag
// - period-ending edge copies count to period, sets flag, clears counter
// - capture count reaching ffff sets overflow flag and clears counter
// - separate enables for width/match, period and overflow interrupts
// - flags set only by hardware; write 0 clears, write 1 keeps
// - first instance in capture mode counts every clock when shared control bit 0 set
// - second instance has prescaler, counter and events only, no pins
// - counter wraps to zero after ffff
`define PCT_T4_CNT_LO 8'h92
`define PCT_T4_CNT_HI 8'h93
`define PCT_T4_DUTY_LO 8'h94
`define PCT_T4_DUTY_HI 8'h95
`define PCT_T4_PER_LO 8'h96
`define PCT_T4_PER_HI 8'h97
`define PCT_T3_CTL_A 8'h9c
`define PCT_T3_CTL_B 8'h9d
`define PCT_T4_CTL_A 8'h9e
`define PCT_T4_CTL_B 8'h9f
`define PCT_T3_CNT_LO 8'ha2
`define PCT_T3_CNT_HI 8'ha3
`define PCT_T3_DUTY_LO 8'ha4
`define PCT_T3_DUTY_HI 8'ha5
`define PCT_T3_PER_LO 8'ha6
`define PCT_T3_PER_HI 8'ha7
`define PCT_SHARED_CTL 8'hb0
// control a fields
`define PCT_A_PSC_HI 7
`define PCT_A_PSC_LO 5
`define PCT_A_POL 4
`define PCT_A_MWIE 3
`define PCT_A_SHOT 1
`define PCT_A_MODE 0
`define PCT_A_WMASK 8'hfb
// control b fields
`define PCT_B_MWF 7
`define PCT_B_PDF 6
`define PCT_B_OVF 5
`define PCT_B_PDIE 4
`define PCT_B_OVIE 3
`define PCT_B_FLT_HI 2
`define PCT_B_FLT_LO 1
`define PCT_B_EN 0
`define PCT_CNT_MAX 16'hffff
`define PCT_FLT_4 5'h04
`define PCT_FLT_8 5'h08
`define PCT_FLT_16 5'h10
`endif

// >>> pct_src.sv
// pwm source model standing on the capture input
module pct_src (
  input wire clk_i, // system clock
  input wire run_i, // emit pulses while high
  input wire [7:0] hi_i, // high length in clocks
  input wire [7:0] lo_i, // low length in clocks
  output logic line_o // pwm line, idles low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  initial line_o = 1'b0;
  always @(posedge clk_i) begin
    if (!run_i) begin
      cnt <= 8'h00;
      line_o <= 1'b0;
    end else if (cnt == (line_o ? hi_i : lo_i) - 8'h01) begin
      cnt <= 8'h00;
      line_o <= !line_o;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // pct_src

// >>> pct_timer.v
// pwm capture timer pair with classic wishbone byte register port
//
// Our own choice: the Wishbone interface to the registers.
`include "pct_map.vh"

// ****************************************
// one timer channel
// ****************************************
module pct_chan #(
  parameter HAS_PIN = 1'b1,
  parameter [7:0] A_CNT_LO = 8'h00,
  parameter [7:0] A_CTL_A = 8'h00
) (
  input wire clk_i,          // system clock
  input wire rst_i,          // sync reset
  input wire wr_i,           // register write strobe
  input wire rd_i,           // register read strobe
  input wire [7:0] adr_i,    // register address
  input wire [7:0] dat_i,    // write data
  input wire fast_i,         // shared control bit 0
  input wire pin_i,          // synchronised capture input
  output reg [7:0] rdat_o,   // read data of this channel
  output reg hit_o,          // address belongs to channel
  output reg wave_o,         // pwm output level
  output reg irq_o           // interrupt request
);
  reg [7:0] ctl_a;
  reg [7:0] ctl_b;
  reg [15:0] cnt;
  reg [15:0] duty;
  reg [15:0] per;
  reg [7:0] lo_latch;
  reg [6:0] pre;
  reg [4:0] fcnt;
  reg filt;
  reg filt_d;
  reg [7:0] next_rdat;
  reg next_hit;
  reg [4:0] flen;
  reg tick;
  wire [2:0] psc = ctl_a[`PCT_A_PSC_HI:`PCT_A_PSC_LO];
  wire [1:0] fsel = ctl_b[`PCT_B_FLT_HI:`PCT_B_FLT_LO];
  wire outmode = ctl_a[`PCT_A_MODE];
  wire pol = ctl_a[`PCT_A_POL];
  wire en = ctl_b[`PCT_B_EN];
  wire capmode = HAS_PIN && !outmode;
  wire rise = filt & ~filt_d;
  wire fall = ~filt & filt_d;
  wire start_edge = pol ? fall : rise;
  wire end_edge = pol ? rise : fall;
  wire [7:0] off = adr_i - A_CNT_LO;
  wire ctl_wr_a = wr_i && adr_i == A_CTL_A;
  wire ctl_wr_b = wr_i && adr_i == A_CTL_A + 8'h01;

  // ****************************************
  // prescaler
  // ****************************************
  always @* begin
    tick = 1'b0;
    case (psc)
      3'h0: tick = 1'b1;
      3'h1: tick = pre[0];
      3'h2: tick = &pre[1:0];
      3'h3: tick = &pre[2:0];
      3'h4: tick = &pre[3:0];
      3'h5: tick = &pre[4:0];
      3'h6: tick = &pre[5:0];
      default: tick = &pre[6:0];
    endcase
    if (capmode && fast_i) begin
      tick = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i || !en) begin
      pre <= 7'h00;
    end else begin
      pre <= pre + 7'h01;
    end
  end

  // ****************************************
  // input noise filter
  // ****************************************
  always @* begin
    case (fsel)
      2'h1: flen = `PCT_FLT_4;
      2'h2: flen = `PCT_FLT_8;
      2'h3: flen = `PCT_FLT_16;
      default: flen = 5'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      fcnt <= 5'h00;
      filt <= 1'b0;
      filt_d <= 1'b0;
    end else begin
      filt_d <= filt;
      if (fsel == 2'h0) begin
        filt <= pin_i;
        fcnt <= 5'h00;
      end else if (pin_i == filt) begin
        fcnt <= 5'h00;
      end else if (fcnt == flen - 5'h01) begin
        filt <= pin_i;
        fcnt <= 5'h00;
      end else begin
        fcnt <= fcnt + 5'h01;
      end
    end
  end

  // ****************************************
  // counter, compare, capture and registers
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl_a <= 8'h00;
      ctl_b <= 8'h00;
      cnt <= 16'h0000;
      duty <= 16'h0000;
      per <= 16'h0000;
      lo_latch <= 8'h00;
      wave_o <= 1'b0;
    end else begin
      if (ctl_wr_a) begin
        ctl_a <= dat_i & `PCT_A_WMASK;
      end
      if (ctl_wr_b) begin
        // flags only cleared by a written zero
        ctl_b[`PCT_B_MWF] <= ctl_b[`PCT_B_MWF] & dat_i[`PCT_B_MWF];
        ctl_b[`PCT_B_PDF] <= ctl_b[`PCT_B_PDF] & dat_i[`PCT_B_PDF];
        ctl_b[`PCT_B_OVF] <= ctl_b[`PCT_B_OVF] & dat_i[`PCT_B_OVF];
        ctl_b[4:0] <= dat_i[4:0];
      end
      if (wr_i) begin
        case (off)
          8'h00: cnt[7:0] <= dat_i;
          8'h01: cnt[15:8] <= dat_i;
          8'h02: duty[7:0] <= dat_i;
          8'h03: duty[15:8] <= dat_i;
          8'h04: per[7:0] <= dat_i;
          8'h05: per[15:8] <= dat_i;
          default: ;
        endcase
      end
      if (rd_i && off == 8'h01) begin
        lo_latch <= cnt[7:0];
      end
      wave_o <= HAS_PIN && outmode && (pol ^ ((cnt > duty) && duty != per));
      if (en && tick && !(wr_i && off < 8'h02)) begin
        if (outmode) begin
          if (cnt == duty) begin
            ctl_b[`PCT_B_MWF] <= 1'b1;
          end
          if (cnt == per) begin
            cnt <= 16'h0000;
            ctl_b[`PCT_B_OVF] <= 1'b1;
            if (ctl_a[`PCT_A_SHOT]) begin
              ctl_b[`PCT_B_EN] <= 1'b0;
            end
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end else begin
          if (capmode && end_edge) begin
            duty <= cnt;
            ctl_b[`PCT_B_MWF] <= 1'b1;
          end
          if (capmode && start_edge) begin
            per <= cnt;
            cnt <= 16'h0000;
            ctl_b[`PCT_B_PDF] <= 1'b1;
            if (ctl_a[`PCT_A_SHOT]) begin
              ctl_b[`PCT_B_EN] <= 1'b0;
            end
          end else if (cnt == `PCT_CNT_MAX) begin
            cnt <= 16'h0000;
            ctl_b[`PCT_B_OVF] <= 1'b1;
            if (ctl_a[`PCT_A_SHOT]) begin
              ctl_b[`PCT_B_EN] <= 1'b0;
            end
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (ctl_b[`PCT_B_MWF] & ctl_a[`PCT_A_MWIE])
        | (ctl_b[`PCT_B_PDF] & ctl_b[`PCT_B_PDIE])
        | (ctl_b[`PCT_B_OVF] & ctl_b[`PCT_B_OVIE]);
    end
  end

  always @* begin
    next_hit = 1'b1;
    next_rdat = 8'h00;
    if (adr_i == A_CTL_A) begin
      next_rdat = ctl_a;
    end else if (adr_i == A_CTL_A + 8'h01) begin
      next_rdat = ctl_b;
    end else begin
      case (off)
        8'h00: next_rdat = lo_latch;
        8'h01: next_rdat = cnt[15:8];
        8'h02: next_rdat = duty[7:0];
        8'h03: next_rdat = duty[15:8];
        8'h04: next_rdat = per[7:0];
        8'h05: next_rdat = per[15:8];
        default: next_hit = 1'b0;
      endcase
    end
    rdat_o = next_rdat;
    hit_o = next_hit;
  end
endmodule // pct_chan

// ****************************************
// top: wishbone slave and two channels
// ****************************************
module pct_timer (
  input wire clk_i,          // 50 MHz system clock
  input wire rst_i,          // sync reset, active high
  input wire cyc_i,          // wishbone cycle
  input wire stb_i,          // wishbone strobe
  input wire we_i,           // wishbone write enable
  input wire [7:0] adr_i,    // byte register address
  input wire [7:0] dat_i,    // write data
  input wire sel_i,          // byte select
  input wire capture_input_i, // external pwm input, async
  output reg [7:0] dat_o,    // read data
  output reg ack_o,          // wishbone acknowledge
  output reg pwm_o,          // pwm waveform output
  output reg irq_o           // combined interrupt request
);
  reg pin_s1;
  reg pin_s2;
  reg fast;
  wire req = cyc_i && stb_i && !ack_o;
  wire wr = req && we_i && sel_i;
  wire rd = req && !we_i;
  wire [7:0] rd3;
  wire [7:0] rd4;
  wire hit3;
  wire hit4;
  wire wave3;
  wire irq3;
  wire irq4;

  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      ack_o <= 1'b0;
      dat_o <= 8'h00;
      fast <= 1'b0;
      pwm_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      pin_s1 <= capture_input_i;
      pin_s2 <= pin_s1;
      ack_o <= req;
      if (wr && adr_i == `PCT_SHARED_CTL) begin
        fast <= dat_i[0];
      end
      if (rd) begin
        dat_o <= hit3 ? rd3 : hit4 ? rd4 :
          (adr_i == `PCT_SHARED_CTL ? {7'h00, fast} : 8'h00);
      end
      pwm_o <= wave3;
      irq_o <= irq3 | irq4;
    end
  end

  pct_chan #(.HAS_PIN(1'b1), .A_CNT_LO(`PCT_T3_CNT_LO), .A_CTL_A(`PCT_T3_CTL_A)) u_t3 (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr), .rd_i(rd), .adr_i(adr_i), .dat_i(dat_i),
    .fast_i(fast), .pin_i(pin_s2), .rdat_o(rd3), .hit_o(hit3), .wave_o(wave3),
    .irq_o(irq3));

  pct_chan #(.HAS_PIN(1'b0), .A_CNT_LO(`PCT_T4_CNT_LO), .A_CTL_A(`PCT_T4_CTL_A)) u_t4 (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr), .rd_i(rd), .adr_i(adr_i), .dat_i(dat_i),
    .fast_i(1'b0), .pin_i(1'b0), .rdat_o(rd4), .hit_o(hit4), .wave_o(),
    .irq_o(irq4));
endmodule // pct_timer

// >>> pct_timer_asserts.sv
// port checker for the pwm capture timer pair
module pct_timer_asserts (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire cyc_i, // cycle
  input wire stb_i, // strobe
  input wire we_i, // write
  input wire [7:0] adr_i, // address
  input wire [7:0] dat_i, // write data
  input wire sel_i, // select
  input wire capture_input_i, // pwm in
  input wire [7:0] dat_o, // read data
  input wire ack_o, // acknowledge
  input wire pwm_o, // pwm out
  input wire irq_o // interrupt
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reg mode3;
  reg [3:0] ien;
  wire wr = ack_o && we_i && sel_i;
  // shadow of mode and interrupt enables
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode3 <= 1'b0;
      ien <= 4'h0;
    end else if (wr) begin
      if (adr_i == 8'h9c) {mode3, ien[0]} <= {dat_i[0], dat_i[3]};
      if (adr_i == 8'h9d) ien[1] <= |dat_i[4:3];
      if (adr_i == 8'h9e) ien[2] <= dat_i[3];
      if (adr_i == 8'h9f) ien[3] <= |dat_i[4:3];
    end
  end
  a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_caused: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  a_unmapped_zero: assert property (ack_o && !we_i && adr_i < 8'h92 |-> dat_o == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_bit: assert property (ack_o && !we_i && (adr_i == 8'h9c || adr_i == 8'h9e)
    |-> !dat_o[2]) else $error("reserved control bit reads one");
  a_capture_no_wave: assert property (!mode3 && $past(!mode3, 2) |-> !pwm_o)
    else $error("waveform in capture mode");
  a_masked_quiet: assert property (ien == 4'h0 && $past(ien) == 4'h0 |-> !irq_o)
    else $error("interrupt with all enables off");
  a_shared_bits: assert property (ack_o && !we_i && adr_i == 8'hb0 |-> dat_o[7:1] == 7'h00)
    else $error("shared control upper bits set");
  cover property (ack_o && !we_i);
  cover property ($rose(pwm_o));
  cover property ($rose(irq_o));
endmodule // pct_timer_asserts

bind pct_timer pct_timer_asserts chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
  .capture_input_i(capture_input_i), .dat_o(dat_o), .ack_o(ack_o), .pwm_o(pwm_o),
  .irq_o(irq_o));

// >>> pct_timer_tb.sv
// self-checking bench for the pwm capture timer pair
module pct_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic sel_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [7:0] dat_i = 8'h00;
  logic run = 1'b0;
  logic [7:0] hi = 8'h14;
  logic [7:0] lo = 8'h1e;
  logic [7:0] rd;
  logic [15:0] du, per;
  wire line, ack_o, pwm_o, irq_o;
  wire [7:0] dat_o;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  always #10 clk_i = ~clk_i;
  pct_timer uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .capture_input_i(line), .dat_o(dat_o),
    .ack_o(ack_o), .pwm_o(pwm_o), .irq_o(irq_o));
  pct_src src (.clk_i(clk_i), .run_i(run), .hi_i(hi), .lo_i(lo), .line_o(line));
  // ****************************************
  // bus cycles and comparison
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    sel_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    check({8'h00, rd}, {8'h00, e});
  endtask
  task automatic pwm_case(input logic [7:0] ca, input logic [7:0] d, input int e);
    int k;
    k = 0;
    wr(8'ha4, d);
    wr(8'h9c, ca);
    repeat (20 << ca[7:5]) @(posedge clk_i);
    repeat (20 << ca[7:5]) begin
      @(posedge clk_i);
      k += (pwm_o === 1'b1);
    end
    check(k[15:0], 16'(e << ca[7:5]));
  endtask
  task automatic wrap_up;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      wrap_up();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 8'h90; a <= 8'hb0; a++) rc(a[7:0], 8'h00);
    wr(8'h80, 8'hff);
    rc(8'h80, 8'h00);
    wr(8'h9c, 8'hff);
    rc(8'h9c, 8'hfb);
    wr(8'h9d, 8'he0);
    rc(8'h9d, 8'h00);
    wr(8'hb0, 8'h01);
    rc(8'hb0, 8'h01);
    wr(8'hb0, 8'h00);
    wr(8'ha2, 8'hff);
    wr(8'ha3, 8'h12);
    rc(8'ha3, 8'h12);
    wr(8'ha2, 8'h00);
    rc(8'ha2, 8'hff);
    rc(8'ha3, 8'h12);
    rc(8'ha2, 8'h00);
    wr(8'ha6, 8'h09);
    wr(8'ha3, 8'h00);
    wr(8'ha2, 8'h00);
    wr(8'h9d, 8'h01);
    for (int c = 0; c < 8; c++) pwm_case({c[2:0], 5'h01}, 8'h03, 12);
    pwm_case(8'h01, 8'h00, 18);
    pwm_case(8'h01, 8'h09, 0);
    pwm_case(8'h11, 8'h09, 20);
    pwm_case(8'h11, 8'h03, 8);
    rc(8'h9d, 8'ha1);
    wr(8'h9d, 8'h00);
    rc(8'h9d, 8'h00);
    wr(8'h9c, 8'h03);
    wr(8'ha3, 8'h00);
    wr(8'ha2, 8'h00);
    wr(8'h9d, 8'h01);
    repeat (30) @(posedge clk_i);
    rc(8'h9d, 8'ha0);
    rc(8'ha3, 8'h00);
    wr(8'h92, 8'hf0);
    wr(8'h93, 8'hff);
    wr(8'h9e, 8'h02);
    wr(8'h9f, 8'h09);
    repeat (40) @(posedge clk_i);
    rc(8'h9f, 8'h28);
    check({15'h0, irq_o}, 16'h1);
    rc(8'h93, 8'h00);
    wr(8'h9f, 8'h08);
    repeat (2) @(posedge clk_i);
    check({15'h0, irq_o}, 16'h0);
    for (int p = 0; p < 2; p++) begin
      wr(8'h9c, {3'h0, p[0], 4'h0});
      wr(8'h9d, 8'h03);
      run <= 1'b1;
      repeat (200) @(posedge clk_i);
      rc(8'h9d, 8'hc3);
      wr(8'h9d, 8'h00);
      run <= 1'b0;
      wb(1'b0, 8'ha4, 8'h00);
      du[7:0] = rd;
      wb(1'b0, 8'ha5, 8'h00);
      du[15:8] = rd;
      wb(1'b0, 8'ha6, 8'h00);
      per[7:0] = rd;
      wb(1'b0, 8'ha7, 8'h00);
      per[15:8] = rd;
      check(per - du, p ? 16'h0014 : 16'h001e);
      check({15'h0, per == 16'h0032 || per == 16'h0031}, 16'h1);
    end
    hi <= 8'h02;
    lo <= 8'h28;
    wr(8'h9c, 8'h00);
    wr(8'h9d, 8'h03);
    run <= 1'b1;
    repeat (200) @(posedge clk_i);
    rc(8'h9d, 8'h03);
    wr(8'h9d, 8'h01);
    repeat (200) @(posedge clk_i);
    rc(8'h9d, 8'hc1);
    wrap_up();
  end
endmodule // pct_timer_tb
